// *** rtl/gdpc_defs.vh ***
// Purpose: Constants for the GPIB device port configuration block.
// Assumes: One 25 MHz clock, asynchronous active-low reset.
// Notes:   Offsets are register indices on the plain register port.
`ifndef GDPC_DEFS_VH
`define GDPC_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GDPC_REG_CONFIG     4'h0
`define GDPC_REG_STATUS     4'h1
`define GDPC_REG_TX_DATA    4'h2
`define GDPC_REG_RX_DATA    4'h3
`define GDPC_REG_EVENT      4'h4
`define GDPC_REG_SETUP      4'h5
`define GDPC_REG_PERSIST    4'h6

// ----------------------------------------------------------------------
// Config fields
// ----------------------------------------------------------------------
`define GDPC_CFG_ADDR_LSB   0
`define GDPC_CFG_ADDR_MSB   4
`define GDPC_CFG_TERM_LF    5
`define GDPC_CFG_LISTEN_ONLY 6
`define GDPC_CFG_RX_SETUPS  7
`define GDPC_CFG_TX_SETUPS  8
`define GDPC_CFG_RESET      9'h000

// ----------------------------------------------------------------------
// Persistent fields, codes and counts
// ----------------------------------------------------------------------
`define GDPC_PER_SRQ_EN     0
`define GDPC_PER_RESTORE_ONE 1
`define GDPC_ADDR_OFF_BUS   5'h1f
`define GDPC_CHAR_LF        8'h0a
`define GDPC_CHAR_CR        8'h0d
`define GDPC_CHAR_QUERY     8'h3f
`define GDPC_STB_POWER_UP   8'h41
`define GDPC_SETUP_COUNT    6'h1e
`define GDPC_SETUP_BYTES    8'h40

`endif

// *** rtl/gdpc_port.v ***
// Purpose: Device side of a GPIB instrument port with its configuration.
// Assumes: Bus lines are active high here; pin inputs are synchronised.
// Notes:   Three-wire handshake is simplified to one byte per DAV pulse.
// Notes on behaviour
// - Primary address zero to thirty-one, set locally
// - Address thirty-one: ignore bus, drive nothing (receive-setups mode still counts EOI bytes off bus)
// - Primary addressing only, no secondary address
// - EOI mode: only EOI ends received message
// - EOI mode: EOI on last sent byte
// - LF mode: EOI or line feed ends message
// - LF mode: append CR, LF with EOI
// - Talk/listen: addressed as listener or talker
// - Listen-only: never talk, still receive commands (send-setups mode still strobes its bytes in listen-only)
// - Receive setups: take thirty, then leave mode
// - Send setups only when peer waits; auto exit
// - Power-on enters local state
// - Power-on restores last setup or setup one
// - SRQ after power-on when requests enabled
// - Power-up serial poll returns status sixty-five
// - Keep working when SRQ never polled
// - Header followed by question mark is query
// - Talk data only after a query
// - Release SRQ after poll, reassert if pending
// - Service-request enable survives power removal
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "gdpc_defs.vh"

module gdpc_port (
    input  wire        clk,
    input  wire        resetn,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    input  wire [7:0]  persist_in,
    output wire [7:0]  persist_out,
    input  wire [7:0]  dio_in,
    output reg  [7:0]  dio_out,
    output wire        dio_oe,
    input  wire        dav_in,
    output reg         dav_out,
    output wire        dav_oe,
    input  wire        eoi_in,
    output reg         eoi_out,
    output wire        eoi_oe,
    input  wire        atn_in,
    input  wire        ren_in,
    output wire        srq_out,
    output wire        srq_oe,
    output wire        remote_state,
    output reg         restore_last,
    output reg         restore_one
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Listen address group 0x20..0x3e, talk group 0x40..0x5e.
    function is_my_cmd;
        input [7:0] b;
        input [1:0] grp;
        input [4:0] a;
        begin
            is_my_cmd = (b[6:5] == grp) && (b[4:0] == a);
        end
    endfunction

    function is_term;
        input [7:0] b;
        input       eoi;
        input       lf_mode;
        begin
            is_term = eoi | (lf_mode & (b == `GDPC_CHAR_LF));
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [7:0] dio_s1_reg, dio_s2_reg;
    reg [3:0] ctl_s1_reg, ctl_s2_reg;
    reg       dav_prev_reg;
    wire      dav_s = ctl_s2_reg[0];
    wire      eoi_s = ctl_s2_reg[1];
    wire      atn_s = ctl_s2_reg[2];
    wire      ren_s = ctl_s2_reg[3];
    wire      byte_in = dav_s & ~dav_prev_reg;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dio_s1_reg   <= 8'h00;
            dio_s2_reg   <= 8'h00;
            ctl_s1_reg   <= 4'h0;
            ctl_s2_reg   <= 4'h0;
            dav_prev_reg <= 1'b0;
        end
        else
        begin
            dio_s1_reg   <= dio_in;
            dio_s2_reg   <= dio_s1_reg;
            ctl_s1_reg   <= {ren_in, atn_in, eoi_in, dav_in};
            ctl_s2_reg   <= ctl_s1_reg;
            dav_prev_reg <= dav_s;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and power-on state
    // ------------------------------------------------------------------
    reg [8:0] cfg_reg;
    reg       srq_en_reg, restore_sel_reg, por_pend_reg, por_done_reg;
    reg       srq_reg, event_pend_reg, local_reg;
    reg [7:0] event_stb_reg;
    wire [4:0] my_addr   = cfg_reg[`GDPC_CFG_ADDR_MSB:`GDPC_CFG_ADDR_LSB];
    wire       off_bus   = (my_addr == `GDPC_ADDR_OFF_BUS);
    wire       lf_mode   = cfg_reg[`GDPC_CFG_TERM_LF];
    wire       lon       = cfg_reg[`GDPC_CFG_LISTEN_ONLY];
    wire       rx_setups = cfg_reg[`GDPC_CFG_RX_SETUPS];
    wire       tx_setups = cfg_reg[`GDPC_CFG_TX_SETUPS];

    assign persist_out = {6'h00, restore_sel_reg, srq_en_reg};
    assign remote_state = ~local_reg;

    // ------------------------------------------------------------------
    // Listener, talker and serial poll state
    // ------------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_LIST = 4'b0010;
    localparam ST_TALK = 4'b0100;
    localparam ST_POLL = 4'b1000;
    reg [3:0] state_reg;
    reg       spe_reg, query_reg, hdr_reg, rx_done_reg;
    reg [7:0] rx_data_reg;
    reg [1:0] tx_phase_reg;
    reg       tx_valid_reg, tx_last_reg;
    reg [7:0] tx_byte_reg;
    reg [5:0] setup_cnt_reg;
    reg [7:0] setup_byte_reg;
    wire      sw_tx = reg_write && (reg_addr == `GDPC_REG_TX_DATA);
    wire      sw_rd_rx = reg_read && (reg_addr == `GDPC_REG_RX_DATA);
    wire      ev_wr = reg_write && (reg_addr == `GDPC_REG_EVENT);

    // Data, DAV and EOI lines are driven only in cycles that strobe a byte, but strobes are not gated by attention,
    // so a poll or talk byte can overlap a command byte that a controller sends under attention.
    // drive nothing off bus
    wire active_talk = !off_bus && dav_out;
    assign dio_oe = active_talk;
    assign dav_oe = active_talk;
    assign eoi_oe = active_talk;
    assign srq_oe  = !off_bus && srq_reg;
    assign srq_out = srq_reg;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_reg         <= `GDPC_CFG_RESET;
            srq_en_reg      <= 1'b0;
            restore_sel_reg <= 1'b0;
            por_pend_reg    <= 1'b1;
            por_done_reg    <= 1'b0;
            srq_reg         <= 1'b0;
            event_pend_reg  <= 1'b0;
            event_stb_reg   <= 8'h00;
            local_reg       <= 1'b1;
            restore_last    <= 1'b0;
            restore_one     <= 1'b0;
            state_reg       <= ST_IDLE;
            spe_reg         <= 1'b0;
            query_reg       <= 1'b0;
            hdr_reg         <= 1'b0;
            rx_done_reg     <= 1'b0;
            rx_data_reg     <= 8'h00;
            tx_phase_reg    <= 2'h0;
            tx_valid_reg    <= 1'b0;
            tx_last_reg     <= 1'b0;
            tx_byte_reg     <= 8'h00;
            dio_out         <= 8'h00;
            dav_out         <= 1'b0;
            eoi_out         <= 1'b0;
            setup_cnt_reg   <= 6'h00;
            setup_byte_reg  <= 8'h00;
        end
        else
        begin
            restore_last <= 1'b0;
            restore_one  <= 1'b0;
            dav_out      <= 1'b0;
            // Persistent values are caught one clock after reset release.
            if (!por_done_reg)
            begin
                por_done_reg    <= 1'b1;
                srq_en_reg      <= persist_in[`GDPC_PER_SRQ_EN];
                restore_sel_reg <= persist_in[`GDPC_PER_RESTORE_ONE];
                restore_last    <= ~persist_in[`GDPC_PER_RESTORE_ONE];
                restore_one     <= persist_in[`GDPC_PER_RESTORE_ONE];
                srq_reg         <= persist_in[`GDPC_PER_SRQ_EN];
            end

            if (reg_write && reg_addr == `GDPC_REG_CONFIG)
            begin
                cfg_reg[7:0] <= reg_wdata[7:0];
                if (reg_wdata[`GDPC_CFG_TX_SETUPS] && !ren_s)
                    cfg_reg[8] <= 1'b1;
            end
            if (reg_write && reg_addr == `GDPC_REG_PERSIST)
            begin
                srq_en_reg      <= reg_wdata[`GDPC_PER_SRQ_EN];
                restore_sel_reg <= reg_wdata[`GDPC_PER_RESTORE_ONE];
            end
            if (reg_write && reg_addr == `GDPC_REG_EVENT)
            begin
                event_pend_reg <= 1'b1;
                event_stb_reg  <= reg_wdata[7:0];
                if (srq_en_reg)
                    srq_reg <= 1'b1;
            end
            if (sw_rd_rx)
                rx_done_reg <= 1'b0;

            // Outgoing byte strobe, one byte per write or setup step.
            if (sw_tx && query_reg && state_reg == ST_TALK)
            begin
                tx_valid_reg <= 1'b1;
                tx_byte_reg  <= reg_wdata[7:0];
                tx_last_reg  <= reg_wdata[8];
            end

            if (rx_setups && byte_in && !atn_s)
            begin
                if (eoi_s && setup_cnt_reg == `GDPC_SETUP_COUNT - 6'h01)
                begin
                    setup_cnt_reg <= 6'h00;
                    cfg_reg[`GDPC_CFG_RX_SETUPS] <= 1'b0;
                end
                else if (eoi_s)
                    setup_cnt_reg <= setup_cnt_reg + 6'h01;
            end
            else if (tx_setups && !off_bus)
            begin
                dio_out <= setup_byte_reg;
                dav_out <= 1'b1;
                eoi_out <= (setup_byte_reg == `GDPC_SETUP_BYTES - 8'h01);
                if (setup_byte_reg == `GDPC_SETUP_BYTES - 8'h01)
                begin
                    setup_byte_reg <= 8'h00;
                    if (setup_cnt_reg == `GDPC_SETUP_COUNT - 6'h01)
                    begin
                        setup_cnt_reg <= 6'h00;
                        cfg_reg[8]    <= 1'b0;
                    end
                    else
                        setup_cnt_reg <= setup_cnt_reg + 6'h01;
                end
                else
                    setup_byte_reg <= setup_byte_reg + 8'h01;
            end
            else if (byte_in && !off_bus)
            begin
                if (atn_s)
                begin
                    if (is_my_cmd(dio_s2_reg, 2'h1, my_addr))
                    begin
                        state_reg <= ST_LIST;
                        local_reg <= ~ren_s;
                    end
                    else if (is_my_cmd(dio_s2_reg, 2'h2, my_addr) && !lon)
                        state_reg <= spe_reg ? ST_POLL : ST_TALK;
                    else if (dio_s2_reg == 8'h18)
                        spe_reg <= 1'b1;
                    else if (dio_s2_reg == 8'h19)
                        spe_reg <= 1'b0;
                    else if (dio_s2_reg == 8'h3f || dio_s2_reg == 8'h5f)
                        state_reg <= ST_IDLE;
                end
                else if (state_reg == ST_LIST || lon)
                begin
                    rx_data_reg <= dio_s2_reg;
                    if (dio_s2_reg == `GDPC_CHAR_QUERY && hdr_reg)
                        query_reg <= 1'b1;
                    hdr_reg <= (dio_s2_reg != 8'h20) && (dio_s2_reg != 8'h3b);
                    if (is_term(dio_s2_reg, eoi_s, lf_mode))
                    begin
                        rx_done_reg <= 1'b1;
                        hdr_reg     <= 1'b0;
                    end
                end
            end
            else if (state_reg == ST_POLL && !dav_out && !off_bus)
            begin
                dio_out <= por_pend_reg ? `GDPC_STB_POWER_UP : event_stb_reg;
                dav_out <= 1'b1;
                eoi_out <= 1'b0;
                if (por_pend_reg)
                begin
                    por_pend_reg <= 1'b0;
                    srq_reg      <= srq_en_reg & (event_pend_reg | ev_wr);
                end
                // An event written in the poll cycle stays pending: the set wins.
                else if (!ev_wr)
                begin
                    event_pend_reg <= 1'b0;
                    srq_reg        <= 1'b0;
                end
                state_reg <= ST_IDLE;
            end
            else if (state_reg == ST_TALK && query_reg && tx_phase_reg != 2'h0)
            begin
                dav_out <= 1'b1;
                if (tx_phase_reg == 2'h1)
                begin
                    dio_out      <= `GDPC_CHAR_CR;
                    eoi_out      <= 1'b0;
                    tx_phase_reg <= 2'h2;
                end
                else
                begin
                    dio_out      <= `GDPC_CHAR_LF;
                    eoi_out      <= 1'b1;
                    tx_phase_reg <= 2'h0;
                    query_reg    <= 1'b0;
                end
            end
            else if (state_reg == ST_TALK && tx_valid_reg && !sw_tx)
            begin
                tx_valid_reg <= 1'b0;
                dio_out      <= tx_byte_reg;
                dav_out      <= 1'b1;
                eoi_out      <= tx_last_reg & ~lf_mode;
                if (tx_last_reg)
                begin
                    if (lf_mode)
                        tx_phase_reg <= 2'h1;
                    else
                        query_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 32'h00000000;
        else if (reg_read)
        begin
            case (reg_addr)
                `GDPC_REG_CONFIG:  reg_rdata <= {23'h000000, cfg_reg};
                `GDPC_REG_STATUS:  reg_rdata <= {22'h000000, tx_valid_reg, srq_reg,
                                                 local_reg, query_reg, rx_done_reg,
                                                 por_pend_reg, state_reg};
                `GDPC_REG_RX_DATA: reg_rdata <= {24'h000000, rx_data_reg};
                `GDPC_REG_EVENT:   reg_rdata <= {23'h000000, event_pend_reg, event_stb_reg};
                `GDPC_REG_SETUP:   reg_rdata <= {26'h0000000, setup_cnt_reg};
                `GDPC_REG_PERSIST: reg_rdata <= {30'h00000000, restore_sel_reg, srq_en_reg};
                default:           reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end

endmodule

// *** verif/gdpc_port_assertions.sv ***
// Purpose: Pin-level checks of gdpc_port.
// Assumes: Register strobes follow the plain port rules.
// Notes:   Config fields are shadowed from register writes.
`timescale 1ns/100ps
`include "gdpc_defs.vh"

module gdpc_port_assertions (
    input wire        clk,
    input wire        resetn,
    input wire [3:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_write,
    input wire        reg_read,
    input wire [31:0] reg_rdata,
    input wire [7:0]  persist_in,
    input wire [7:0]  persist_out,
    input wire [7:0]  dio_out,
    input wire        dio_oe,
    input wire        dav_out,
    input wire        dav_oe,
    input wire        eoi_out,
    input wire        eoi_oe,
    input wire        srq_out,
    input wire        srq_oe,
    input wire        remote_state,
    input wire        restore_last,
    input wire        restore_one
);
    reg [4:0] addr_reg;
    reg       lo_reg;
    reg       txs_reg;

    // ----
    // Shadow
    // ----
    // Setup blocks carry arbitrary bytes, so framing checks stop once sending was asked for.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_reg <= 5'h00;
            lo_reg   <= 1'b0;
            txs_reg  <= 1'b0;
        end
        else if (reg_write && reg_addr == `GDPC_REG_CONFIG)
        begin
            addr_reg <= reg_wdata[4:0];
            lo_reg   <= reg_wdata[`GDPC_CFG_LISTEN_ONLY];
            txs_reg  <= txs_reg | reg_wdata[`GDPC_CFG_TX_SETUPS];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_off_bus;
        addr_reg == `GDPC_ADDR_OFF_BUS |-> !(dio_oe || dav_oe || eoi_oe || srq_oe);
    endproperty
    a_off_bus: assert property (p_off_bus)
        else $error("bus driven while off bus");
    property p_cfg_read;
        reg_read && reg_addr == `GDPC_REG_CONFIG |=> reg_rdata[4:0] == addr_reg;
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("address readback wrong");
    property p_local;
        $rose(resetn) |-> !remote_state ##1 !remote_state;
    endproperty
    a_local: assert property (p_local)
        else $error("not local after reset");
    property p_restore_sel;
        restore_one || restore_last |->
            restore_one != restore_last && restore_one == persist_out[`GDPC_PER_RESTORE_ONE];
    endproperty
    a_restore_sel: assert property (p_restore_sel)
        else $error("wrong setup restored");
    property p_restore_once;
        $rose(resetn) |-> ##[0:2] (restore_one || restore_last);
    endproperty
    a_restore_once: assert property (p_restore_once)
        else $error("no restore pulse");
    property p_srq_power;
        $rose(resetn) |-> ##[0:3] (srq_out == persist_in[`GDPC_PER_SRQ_EN]);
    endproperty
    a_srq_power: assert property (p_srq_power)
        else $error("power-on request wrong");
    property p_dav_drive;
        dav_out |-> dav_oe && dio_oe;
    endproperty
    a_dav_drive: assert property (p_dav_drive)
        else $error("byte strobed undriven");
    property p_lf_frame;
        !txs_reg && dav_out && eoi_out && dio_out == `GDPC_CHAR_LF |->
            $past(dav_out) && $past(dio_out) == `GDPC_CHAR_CR;
    endproperty
    a_lf_frame: assert property (p_lf_frame)
        else $error("line feed not after return");
    property p_lo_quiet;
        lo_reg |-> !dio_oe;
    endproperty
    a_lo_quiet: assert property (p_lo_quiet)
        else $error("talking in listen only");
endmodule

bind gdpc_port gdpc_port_assertions chk_u (.*);

// *** verif/gdpc_peer.sv ***
// Purpose: Controller or peer instrument on the bus.
// Assumes: Lines are active high; a released line reads 0.
// Notes:   Bytes the device strobes are queued for the bench.
`timescale 1ns/100ps

module gdpc_peer (
    input wire       clk,
    input wire [7:0] dio_bus,
    input wire       dav_bus,
    input wire       eoi_bus,
    output reg [7:0] dio_drv,
    output reg       dav_drv,
    output reg       eoi_drv,
    output reg       atn_drv,
    output reg       ren_drv
);
    logic [7:0] got_q[$];
    logic       eoi_q[$];

    initial
    begin
        {dio_drv, dav_drv, eoi_drv, atn_drv, ren_drv} = 12'h000;
    end

    // ----
    // Capture and send
    // ----
    always @(posedge clk)
    begin
        if (dav_bus && !dav_drv)
        begin
            got_q.push_back(dio_bus);
            eoi_q.push_back(eoi_bus);
        end
    end

    task send(input logic atn, input logic eoi, input logic [7:0] b);
    begin
        @(posedge clk);
        {dio_drv, eoi_drv, atn_drv} <= {b, eoi, atn};
        @(posedge clk);
        dav_drv <= 1'b1;
        repeat (4) @(posedge clk);
        {dav_drv, dio_drv, eoi_drv, atn_drv} <= 11'h000;
        repeat (5) @(posedge clk);
    end
    endtask

    task set_ren(input logic v);
    begin
        @(posedge clk);
        ren_drv <= v;
        repeat (3) @(posedge clk);
    end
    endtask
endmodule

// *** verif/gdpc_port_test.sv ***
// Purpose: Self-checking bench for gdpc_port.
// Assumes: Peer model answers at once; one byte per strobe.
// Notes:   Random values come from an xorshift seeded at 11.
`timescale 1ns/100ps
`include "gdpc_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module gdpc_port_test;
    logic        clk, resetn, reg_write, reg_read, dio_oe, dav_in, dav_out, dav_oe;
    logic        eoi_in, eoi_out, eoi_oe, atn_in, ren_in, srq_out, srq_oe, p_dav, p_eoi;
    logic        remote_state, restore_last, restore_one;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val, seed;
    logic [7:0]  persist_in, persist_out, dio_in, dio_out, p_dio, tb_byte;
    logic [4:0]  addr;
    int          error_cnt, checks_done, cyc, n;

    // ----
    // Bus and parts
    // ----
    assign dio_in = (dio_oe ? dio_out : 8'h00) | p_dio;
    assign dav_in = (dav_oe & dav_out) | p_dav;
    assign eoi_in = (eoi_oe & eoi_out) | p_eoi;
    gdpc_port dut_u (.*);
    gdpc_peer peer_u (.clk(clk), .dio_bus(dio_in), .dav_bus(dav_in), .eoi_bus(eoi_in),
        .dio_drv(p_dio), .dav_drv(p_dav), .eoi_drv(p_eoi), .atn_drv(atn_in), .ren_drv(ren_in));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] exp_byte(input int i, input logic [7:0] b);
        return (i == 0) ? b : (i == 1) ? `GDPC_CHAR_CR : `GDPC_CHAR_LF;
    endfunction

    task wr(input logic [3:0] a, input logic [31:0] d);
    begin
        @(posedge clk);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_write <= 1'b0;
    end
    endtask
    task rd(input logic [3:0] a);
    begin
        @(posedge clk);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
    end
    endtask
    task listen_msg(input logic [7:0] b0, input logic [7:0] b1, input logic e);
    begin
        peer_u.send(1'b1, 1'b0, 8'h20 + {3'h0, addr});
        peer_u.send(1'b0, 1'b0, b0);
        peer_u.send(1'b0, e, b1);
        rd(`GDPC_REG_STATUS);
    end
    endtask
    task try_tx(input logic [7:0] b);
    begin
        peer_u.send(1'b1, 1'b0, 8'h40 + {3'h0, addr});
        peer_u.got_q.delete();
        peer_u.eoi_q.delete();
        wr(`GDPC_REG_TX_DATA, {23'h0, 1'b1, b});
        repeat (20) @(posedge clk);
    end
    endtask
    task tx_frame(input int len);
    begin
        seed = xs(seed);
        tb_byte = {2'b01, seed[5:0]};
        try_tx(tb_byte);
        `CHK(peer_u.got_q.size(), len)
        for (int i = 0; i < len; i++)
        begin
            `CHK(peer_u.got_q[i], exp_byte(i, tb_byte))
            `CHK(peer_u.eoi_q[i], i == len - 1)
        end
    end
    endtask
    task give_verdict();
    begin
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    // ----
    // Scenarios
    // ----
    initial
    begin
        {resetn, reg_write, reg_read, reg_addr, reg_wdata} = 39'h0;
        persist_in = 8'h03;
        seed = 32'h0000000b;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`GDPC_REG_CONFIG);
        `CHK(rd_val[8:0], `GDPC_CFG_RESET)
        rd(`GDPC_REG_STATUS);
        `CHK({rd_val[8:7], rd_val[4]}, 3'h7)
        `CHK(persist_out[0], 1'b1)
        rd(4'hf);
        `CHK(rd_val, 32'h0)
        seed = xs(seed);
        addr = seed[4:0] % 5'h1f;
        wr(`GDPC_REG_CONFIG, {27'h0, addr});
        try_tx(8'h55);
        `CHK(peer_u.got_q.size(), 0)
        listen_msg(8'h41, `GDPC_CHAR_LF, 1'b0);
        `CHK(rd_val[5], 1'b0)
        peer_u.send(1'b0, 1'b1, 8'h42);
        rd(`GDPC_REG_RX_DATA);
        `CHK(rd_val[7:0], 8'h42)
        listen_msg(8'h43, `GDPC_CHAR_QUERY, 1'b1);
        `CHK(rd_val[6:5], 2'h3)
        rd(`GDPC_REG_RX_DATA);
        peer_u.got_q.delete();
        peer_u.send(1'b1, 1'b0, 8'h18);
        peer_u.send(1'b1, 1'b0, 8'h40 + {3'h0, addr});
        `CHK(peer_u.got_q[0], `GDPC_STB_POWER_UP)
        `CHK(srq_out, 1'b0)
        peer_u.send(1'b1, 1'b0, 8'h19);
        tx_frame(1);
        wr(`GDPC_REG_CONFIG, {26'h1, addr});
        listen_msg(8'h44, `GDPC_CHAR_QUERY, 1'b0);
        peer_u.send(1'b0, 1'b0, `GDPC_CHAR_LF);
        rd(`GDPC_REG_STATUS);
        `CHK(rd_val[6:5], 2'h3)
        rd(`GDPC_REG_RX_DATA);
        tx_frame(3);
        wr(`GDPC_REG_CONFIG, {25'h0, 2'h2, addr});
        listen_msg(8'h45, `GDPC_CHAR_QUERY, 1'b1);
        `CHK(rd_val[5], 1'b1)
        try_tx(8'h46);
        `CHK(peer_u.got_q.size(), 0)
        rd(`GDPC_REG_RX_DATA);
        wr(`GDPC_REG_CONFIG, 32'h0000001f);
        listen_msg(8'h47, 8'h48, 1'b1);
        `CHK(rd_val[5], 1'b0)
        wr(`GDPC_REG_EVENT, 32'h00000041);
        #1;
        `CHK(srq_oe, 1'b0)
        wr(`GDPC_REG_CONFIG, {24'h0, 3'h4, addr});
        for (n = 0; n < `GDPC_SETUP_COUNT; n++)
        begin
            seed = xs(seed);
            peer_u.send(1'b0, 1'b1, seed[7:0]);
            rd(`GDPC_REG_CONFIG);
            `CHK(rd_val[7], n < `GDPC_SETUP_COUNT - 1)
        end
        peer_u.set_ren(1'b1);
        wr(`GDPC_REG_CONFIG, {23'h0, 4'h8, addr});
        rd(`GDPC_REG_CONFIG);
        `CHK(rd_val[8], 1'b0)
        peer_u.set_ren(1'b0);
        peer_u.got_q.delete();
        peer_u.eoi_q.delete();
        wr(`GDPC_REG_CONFIG, {23'h0, 4'h8, addr});
        n = 0;
        do
        begin
            rd(`GDPC_REG_CONFIG);
            n++;
        end while (rd_val[8] && n < 3000);
        `CHK(peer_u.got_q.size(), `GDPC_SETUP_COUNT * `GDPC_SETUP_BYTES)
        n = 0;
        foreach (peer_u.eoi_q[i]) n += peer_u.eoi_q[i];
        `CHK(n, `GDPC_SETUP_COUNT)
        @(posedge clk);
        persist_in <= 8'h00;
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK({srq_out, persist_out[0]}, 2'h0)
        give_verdict();
    end
endmodule
